// ### hw/smc_core_end.sv
// Processor core end: issues register writes, read-back and sleep.
// Assumes the mode controller end on the same mclk.
`timescale 1ns/100ps
`default_nettype none
module smc_core_end (
    input wire logic mclk,
    input wire logic sys_rst,
    smc_link_if.core link,
    input wire logic cmd_go,
    input wire logic [7:0] cmd_ctrl,
    input wire logic cmd_deep,
    input wire logic cmd_readback,
    input wire logic cmd_wake,
    output logic done,
    output logic [3:0] entered_mode
);
    import smc_pkg::*;

    typedef enum logic [2:0] {
        SMC_C_IDLE,
        SMC_C_WRITE,
        SMC_C_READ,
        SMC_C_WAITRD,
        SMC_C_WFI,
        SMC_C_SLEEP
    } smc_core_state_t;

    // ------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------
    smc_core_state_t st_q, st_d;
    logic wr_q, wr_d, rd_q, rd_d, slp_q, slp_d, deep_q, deep_d;
    logic [7:0] data_q, data_d;
    logic rb_q, rb_d, done_q, done_d, wake_q, wake_d;
    logic [3:0] em_q, em_d;

    always_comb begin
        st_d = st_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        slp_d = slp_q;
        deep_d = deep_q;
        data_d = data_q;
        rb_d = rb_q;
        done_d = 1'b0;
        wake_d = 1'b0;
        em_d = link.mode;
        unique case (st_q)
            SMC_C_IDLE: begin
                if (cmd_go) begin
                    data_d = cmd_ctrl;
                    deep_d = cmd_deep;
                    rb_d = cmd_readback;
                    wr_d = 1'b1;
                    st_d = SMC_C_WRITE;
                end
            end
            SMC_C_WRITE: begin
                // Without read-back, sleep is not held back
                if (rb_q) begin
                    rd_d = 1'b1;
                    st_d = SMC_C_WAITRD;
                end else begin
                    st_d = SMC_C_WFI;
                end
            end
            SMC_C_WAITRD: begin
                if (link.rd_valid) begin
                    st_d = SMC_C_WFI;
                end
            end
            SMC_C_READ: begin
                st_d = SMC_C_WAITRD;
            end
            SMC_C_WFI: begin
                slp_d = 1'b1;
                st_d = SMC_C_SLEEP;
            end
            SMC_C_SLEEP: begin
                if (cmd_wake) begin
                    wake_d = 1'b1;
                    slp_d = 1'b0;
                    done_d = 1'b1;
                    st_d = SMC_C_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= SMC_C_IDLE;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            slp_q <= 1'b0;
            deep_q <= 1'b0;
            data_q <= SMC_CTRL_RST;
            rb_q <= 1'b0;
            done_q <= 1'b0;
            wake_q <= 1'b0;
            em_q <= 4'h0;
        end else begin
            st_q <= st_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            slp_q <= slp_d;
            deep_q <= deep_d;
            data_q <= data_d;
            rb_q <= rb_d;
            done_q <= done_d;
            wake_q <= wake_d;
            em_q <= em_d;
        end
    end

    assign link.wr_req = wr_q;
    assign link.rd_req = rd_q;
    assign link.wr_data = data_q;
    assign link.sleep_req = slp_q;
    assign link.deep_sleep_request = deep_q;
    assign link.wake = wake_q;
    assign done = done_q;
    assign entered_mode = em_q;

endmodule
`default_nettype wire

// ### hw/smc_link_if.sv
// Interface between the mode controller and the processor core end.
// Assumes both ends run on the same mclk.
`timescale 1ns/100ps
`default_nettype none
interface smc_link_if;
    logic wr_req;
    logic rd_req;
    logic [7:0] wr_data;
    logic busy;
    logic rd_valid;
    logic [7:0] rd_data;
    logic sleep_req;
    logic deep_sleep_request;
    logic wake;
    logic [3:0] mode;

    modport ctrl (
        input wr_req, rd_req, wr_data, sleep_req, deep_sleep_request, wake,
        output busy, rd_valid, rd_data, mode
    );
    modport core (
        output wr_req, rd_req, wr_data, sleep_req, deep_sleep_request, wake,
        input busy, rd_valid, rd_data, mode
    );
endinterface
`default_nettype wire

// ### hw/smc_pkg.sv
// Package for the system mode controller entry block and its core end.
// Assumes one clock (mclk, 250 MHz) and a synchronous active-high reset.
package smc_pkg;

    // ------------------------------------------------------------
    // Controller versions and mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] SMC_VER_V1 = 3'h1;
    localparam logic [2:0] SMC_VER_V2 = 3'h2;
    localparam logic [2:0] SMC_VER_V3 = 3'h3;
    localparam logic [2:0] SMC_VER_V4 = 3'h4;
    localparam logic [2:0] SMC_VER_V5 = 3'h5;

    // Stop mode selection codes
    localparam logic [2:0] SMC_STOP_MODE_SELECT_NORMAL = 3'h0;
    localparam logic [2:0] SMC_STOP_MODE_SELECT_VLPS = 3'h2;
    localparam logic [2:0] SMC_STOP_MODE_SELECT_LLS = 3'h3;
    localparam logic [2:0] SMC_STOP_MODE_SELECT_VLLS = 3'h4;

    // Power mode control register layout
    localparam int SMC_STOP_MODE_SELECT_LSB = 0;
    localparam int SMC_STOP_MODE_SELECT_W = 3;
    localparam int SMC_LLSM_LSB = 3;
    localparam int SMC_LLSM_W = 2;
    localparam int SMC_HSRUN_BIT = 5;
    localparam int SMC_CTRL_W = 8;
    localparam logic [7:0] SMC_CTRL_RST = 8'h00;

    // Partial leakage sub-modes, also lowest leakage stop
    localparam logic [1:0] SMC_LLSM_FULL = 2'h0;
    localparam logic [1:0] SMC_LLSM_PART_A = 2'h2;
    localparam logic [1:0] SMC_LLSM_PART_B = 2'h3;
    localparam logic [1:0] SMC_LLSM_LOWEST = 2'h1;

    // Register write latencies and core sleep delay in clock cycles
    localparam logic [2:0] SMC_CTRL_WR_CYC = 3'h4;
    localparam logic [2:0] SMC_PERIPH_WR_CYC = 3'h3;
    localparam logic [2:0] SMC_SLEEP_DLY_CYC = 3'h1;

    typedef enum logic [3:0] {
        SMC_MODE_RUN,
        SMC_MODE_HSRUN,
        SMC_MODE_WAIT,
        SMC_MODE_STOP,
        SMC_MODE_VLPS,
        SMC_MODE_LLS,
        SMC_MODE_PART_A,
        SMC_MODE_PART_B,
        SMC_MODE_VLLS,
        SMC_MODE_LOWEST
    } smc_mode_t;

endpackage

// ### hw/smc_system_mode_ctrl.sv
// Mode controller end: control register, write latency, mode entry FSM.
// Assumes the core end drives the link on the same clock.
//
// What this block does
// - Mode control is a compatible state machine.
// - Control register write takes four cycles.
// - Ordinary peripheral writes take three cycles.
// - Core raises sleep one cycle after instruction.
// - Early sleep uses the old selection.
// - Core does not wait for pending writes.
// - Read after write returns after write.
// - Core writes, reads back, then sleeps.
// - Version two adds lowest leakage stop.
// - Version three adds two partial stops.
// - Version four has run, wait, stop.
`timescale 1ns/100ps
`default_nettype none
module smc_system_mode_ctrl #(
    parameter logic [2:0] VERSION = 3'h3
) (
    input wire logic mclk,
    input wire logic sys_rst,
    smc_link_if.ctrl link,
    output logic [7:0] power_mode_control_reg,
    output logic low_power_active
);
    import smc_pkg::*;

    typedef enum logic [1:0] {
        SMC_ST_RUN,
        SMC_ST_ENTER,
        SMC_ST_LOW
    } smc_state_t;

    // ------------------------------------------------------------
    // Write pipeline and control register
    // ------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] pend_q, pend_d;
    logic [2:0] wcnt_q, wcnt_d;
    logic rd_pend_q, rd_pend_d;
    logic rd_valid_q, rd_valid_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic busy_q, busy_d;

    // Mode entry state
    smc_state_t st_q, st_d;
    smc_mode_t mode_q, mode_d;
    logic [7:0] samp_q, samp_d;
    logic lp_q, lp_d;

    function automatic smc_mode_t smc_decode(
        input logic [7:0] c,
        input logic deep
    );
        logic [2:0] sm;
        logic [1:0] ll;
        sm = c[SMC_STOP_MODE_SELECT_LSB +: SMC_STOP_MODE_SELECT_W];
        ll = c[SMC_LLSM_LSB +: SMC_LLSM_W];
        smc_decode = deep ? SMC_MODE_STOP : SMC_MODE_WAIT;
        if (deep && VERSION != SMC_VER_V4) begin
            if (sm == SMC_STOP_MODE_SELECT_VLPS) begin
                smc_decode = SMC_MODE_VLPS;
            end else if (sm == SMC_STOP_MODE_SELECT_LLS) begin
                smc_decode = SMC_MODE_LLS;
                if (VERSION >= SMC_VER_V3 && ll == SMC_LLSM_PART_A) begin
                    smc_decode = SMC_MODE_PART_A;
                end else if (VERSION >= SMC_VER_V3 &&
                             ll == SMC_LLSM_PART_B) begin
                    smc_decode = SMC_MODE_PART_B;
                end
            end else if (sm == SMC_STOP_MODE_SELECT_VLLS) begin
                smc_decode = SMC_MODE_VLLS;
                if (VERSION >= SMC_VER_V2 && ll == SMC_LLSM_LOWEST) begin
                    smc_decode = SMC_MODE_LOWEST;
                end
            end
        end
    endfunction

    always_comb begin
        ctrl_d = ctrl_q;
        pend_d = pend_q;
        wcnt_d = wcnt_q;
        rd_pend_d = rd_pend_q;
        rd_valid_d = 1'b0;
        rd_data_d = rd_data_q;
        busy_d = busy_q;
        if (wcnt_q != 3'h0) begin
            wcnt_d = wcnt_q - 3'h1;
            if (wcnt_q == 3'h1) begin
                ctrl_d = pend_q;
                busy_d = 1'b0;
            end
        end else if (link.wr_req) begin
            pend_d = link.wr_data;
            wcnt_d = SMC_CTRL_WR_CYC;
            // Longer than an ordinary three-cycle write
            busy_d = 1'b1;
        end
        // Read held back until write lands
        if (rd_pend_q && wcnt_q == 3'h0 && !link.wr_req) begin
            rd_pend_d = 1'b0;
            rd_valid_d = 1'b1;
            rd_data_d = ctrl_q;
        end
        // New read wins over the one just answered
        if (link.rd_req) begin
            rd_pend_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_q <= SMC_CTRL_RST;
            pend_q <= SMC_CTRL_RST;
            wcnt_q <= 3'h0;
            rd_pend_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
            busy_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pend_q <= pend_d;
            wcnt_q <= wcnt_d;
            rd_pend_q <= rd_pend_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            busy_q <= busy_d;
        end
    end

    // ------------------------------------------------------------
    // Mode entry state machine
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        mode_d = mode_q;
        samp_d = samp_q;
        lp_d = lp_q;
        unique case (st_q)
            SMC_ST_RUN: begin
                mode_d = (VERSION == SMC_VER_V5 && ctrl_q[SMC_HSRUN_BIT])
                         ? SMC_MODE_HSRUN : SMC_MODE_RUN;
                if (link.sleep_req) begin
                    // Current register value, even with write pending
                    samp_d = ctrl_q;
                    st_d = SMC_ST_ENTER;
                end
            end
            SMC_ST_ENTER: begin
                mode_d = smc_decode(samp_q, link.deep_sleep_request);
                lp_d = 1'b1;
                st_d = SMC_ST_LOW;
            end
            SMC_ST_LOW: begin
                if (link.wake) begin
                    lp_d = 1'b0;
                    st_d = SMC_ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= SMC_ST_RUN;
            mode_q <= SMC_MODE_RUN;
            samp_q <= SMC_CTRL_RST;
            lp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            mode_q <= mode_d;
            samp_q <= samp_d;
            lp_q <= lp_d;
        end
    end

    assign link.busy = busy_q;
    assign link.rd_valid = rd_valid_q;
    assign link.rd_data = rd_data_q;
    assign link.mode = mode_q;
    assign power_mode_control_reg = ctrl_q;
    assign low_power_active = lp_q;

endmodule
`default_nettype wire

// ### verification/smc_link_checker.sv
// Checker for the link between the mode controller and the core end.
// Assumes all link signals on mclk with synchronous reset sys_rst.
`timescale 1ns/100ps
`default_nettype none
module smc_link_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wr_req,
    input wire logic rd_req,
    input wire logic [7:0] wr_data,
    input wire logic busy,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic sleep_req,
    input wire logic deep_sleep_request,
    input wire logic wake,
    input wire logic [3:0] mode
);
    import smc_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_busy_window: assert property (
        wr_req && !busy |=> busy [*4] ##1 !busy)
        else $error("busy window after write wrong");
    a_read_after_wr: assert property (
        rd_valid |-> !busy)
        else $error("read answered while write pending");
    a_read_pulse: assert property (
        rd_valid |=> !rd_valid)
        else $error("read valid longer than one cycle");
    a_read_bounded: assert property (
        rd_req |-> ##[1:8] rd_valid)
        else $error("read never answered");
    a_sleep_enter: assert property (
        $rose(sleep_req) && mode == SMC_MODE_RUN |-> ##2 mode != SMC_MODE_RUN)
        else $error("sleep request did not leave run");
    a_wait_entry: assert property (
        $rose(sleep_req) && !deep_sleep_request && mode == SMC_MODE_RUN
        |-> ##2 mode == SMC_MODE_WAIT)
        else $error("light sleep did not enter wait");
    a_deep_entry: assert property (
        $rose(sleep_req) && deep_sleep_request && mode == SMC_MODE_RUN
        |-> ##2 (mode != SMC_MODE_WAIT && mode != SMC_MODE_RUN))
        else $error("deep sleep did not enter a stop mode");
    a_mode_held: assert property (
        mode != SMC_MODE_RUN && !wake && !$past(wake) |=> $stable(mode))
        else $error("low power mode changed without wake");
    a_wake_exit: assert property (
        wake && mode != SMC_MODE_RUN |-> ##2 mode == SMC_MODE_RUN)
        else $error("wake did not return to run");
endmodule
`default_nettype wire

// ### verification/system_mode_controller_entry_test.sv
// Testbench joining the mode controller and the core end over the link.
// Assumes version three mode set and mclk at 250 MHz.
`timescale 1ns/100ps
`default_nettype none
module system_mode_controller_entry_test;
    import smc_pkg::*;

    typedef struct {
        logic [7:0] ctrl;
        logic deep;
        smc_mode_t mode;
    } smc_row_t;

    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_go = 1'b0;
    logic [7:0] cmd_ctrl = 8'h00;
    logic cmd_deep = 1'b0;
    logic cmd_readback = 1'b0;
    logic cmd_wake = 1'b0;
    logic done;
    logic [3:0] entered_mode;
    logic [7:0] power_mode_control_reg;
    logic low_power_active;
    logic [3:0] entered_mode4;
    logic [7:0] last_rd = 8'h00;
    int failures = 0;
    int checked = 0;
    smc_row_t rows [8] = '{
        '{8'h00, 1'b1, SMC_MODE_STOP}, '{8'h02, 1'b1, SMC_MODE_VLPS},
        '{8'h03, 1'b1, SMC_MODE_LLS}, '{8'h13, 1'b1, SMC_MODE_PART_A},
        '{8'h1b, 1'b1, SMC_MODE_PART_B}, '{8'h04, 1'b1, SMC_MODE_VLLS},
        '{8'h0c, 1'b1, SMC_MODE_LOWEST}, '{8'h02, 1'b0, SMC_MODE_WAIT}};

    smc_link_if link ();

    smc_system_mode_ctrl #(.VERSION(SMC_VER_V3)) i_smc_system_mode_ctrl (
        .mclk(mclk), .sys_rst(sys_rst), .link(link),
        .power_mode_control_reg(power_mode_control_reg),
        .low_power_active(low_power_active));

    smc_core_end i_smc_core_end (
        .mclk(mclk), .sys_rst(sys_rst), .link(link), .cmd_go(cmd_go),
        .cmd_ctrl(cmd_ctrl), .cmd_deep(cmd_deep),
        .cmd_readback(cmd_readback), .cmd_wake(cmd_wake), .done(done),
        .entered_mode(entered_mode));

    // Second pair with the reduced mode set
    smc_link_if link4 ();

    smc_system_mode_ctrl #(
        .VERSION(SMC_VER_V4)
    ) i_smc_system_mode_ctrl_v4 (
        .mclk(mclk), .sys_rst(sys_rst), .link(link4),
        .power_mode_control_reg(), .low_power_active());

    smc_core_end i_smc_core_end_v4 (
        .mclk(mclk), .sys_rst(sys_rst), .link(link4), .cmd_go(cmd_go),
        .cmd_ctrl(cmd_ctrl), .cmd_deep(cmd_deep),
        .cmd_readback(cmd_readback), .cmd_wake(cmd_wake), .done(),
        .entered_mode(entered_mode4));

    // Last read answer, taken while it stands
    always @(posedge mclk) begin
        if (link.rd_valid === 1'b1) begin
            last_rd <= link.rd_data;
        end
    end

    smc_link_checker i_smc_link_checker (
        .mclk(mclk), .sys_rst(sys_rst), .wr_req(link.wr_req),
        .rd_req(link.rd_req), .wr_data(link.wr_data), .busy(link.busy),
        .rd_valid(link.rd_valid), .rd_data(link.rd_data),
        .sleep_req(link.sleep_req),
        .deep_sleep_request(link.deep_sleep_request), .wake(link.wake),
        .mode(link.mode));

    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic check_reg(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_mode(string what, smc_mode_t exp, logic [3:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_flag(ref logic flag, input string what);
        int n;
        for (n = 0; n < 40 && flag !== 1'b1; n++) @(posedge mclk) #1;
        if (flag !== 1'b1) begin
            failures++;
            $display("CHECK FAILED %s expected 1 seen %b", what, flag);
        end
    endtask

    // One entry and exit: command, low power, wake, back in run
    task automatic run(logic [7:0] c, logic d, logic rb, smc_mode_t m);
        smc_mode_t m4;
        m4 = SMC_MODE_WAIT;
        if (d) m4 = SMC_MODE_STOP;
        @(posedge mclk) #1;
        cmd_go = 1'b1;
        cmd_ctrl = c;
        cmd_deep = d;
        cmd_readback = rb;
        @(posedge mclk) #1;
        cmd_go = 1'b0;
        wait_flag(low_power_active, "low_power_active");
        repeat (2) @(posedge mclk) #1;
        check_mode("entered_mode", m, entered_mode);
        check_mode("v4 mode", m4, entered_mode4);
        if (rb) check_reg("read back", c, last_rd);
        cmd_wake = 1'b1;
        @(posedge mclk) #1;
        cmd_wake = 1'b0;
        wait_flag(done, "done");
        repeat (2) @(posedge mclk) #1;
        check_mode("mode after wake", SMC_MODE_RUN, link.mode);
        check_reg("low_power_active", 8'h00, {7'h0, low_power_active});
        check_reg("control reg", c, power_mode_control_reg);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge mclk);
        #1 sys_rst = 1'b0;
        check_reg("control reg", SMC_CTRL_RST, power_mode_control_reg);
        check_mode("mode", SMC_MODE_RUN, link.mode);
        check_reg("busy", 8'h00, {7'h0, link.busy});
        $display("test reset values done");
        // Mode table, each with read back before sleep
        foreach (rows[i]) begin
            run(rows[i].ctrl, rows[i].deep, 1'b1, rows[i].mode);
        end
        $display("test mode table done");
        // Sleep races the write: old selection used without read back, new one with it
        run(8'h00, 1'b1, 1'b0, SMC_MODE_VLPS);
        run(8'h00, 1'b1, 1'b1, SMC_MODE_STOP);
        $display("test write race done");
        // Reset while in low power
        @(posedge mclk) #1;
        cmd_go = 1'b1;
        cmd_ctrl = 8'h03;
        @(posedge mclk) #1;
        cmd_go = 1'b0;
        wait_flag(low_power_active, "low_power_active");
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk) #1;
        sys_rst = 1'b0;
        check_mode("mode", SMC_MODE_RUN, link.mode);
        check_reg("control reg", 8'h00, power_mode_control_reg);
        check_reg("low_power_active", 8'h00, {7'h0, low_power_active});
        run(8'h02, 1'b1, 1'b1, SMC_MODE_VLPS);
        $display("test mid reset done");
        final_report();
    end
endmodule
`default_nettype wire
